/* tisc_pkg.sv */
// Purpose: shared constants for the timer, interrupt and status control block
// Assumes: one core clock, machine cycle marked by an address latch strobe pulse
// Notes: program status word layout and stack area placement live here
package tisc_pkg;
  // ----------------------------------------------------------------
  // program status word fields
  // ----------------------------------------------------------------
  localparam int STW_SP_LSB = 0;
  localparam int STW_SP_MSB = 2;
  localparam int STW_UNUSED = 3;
  localparam int STW_BANK = 4;
  localparam int STW_FLAG0 = 5;
  localparam int STW_HALF = 6;
  localparam int STW_CARRY = 7;
  localparam logic [7:0] STW_RESET = 8'h08;
  // ----------------------------------------------------------------
  // vectors and ram placement
  // ----------------------------------------------------------------
  localparam logic [11:0] VEC_RESET = 12'h000;
  localparam logic [11:0] VEC_EXT = 12'h003;
  localparam logic [11:0] VEC_TMR = 12'h007;
  localparam logic [6:0] STACK_BASE = 7'h08;
  localparam logic [6:0] BANK0_BASE = 7'h00;
  localparam logic [6:0] BANK1_BASE = 7'h18;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int TIMER_DIV = 480;
  localparam int PRESCALE_W = 9;
  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(TIMER_DIV - 1);
  localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 9'h000;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  // ----------------------------------------------------------------
  // counter modes, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TISC_STOPPED = 3'b001,
    TISC_TIMER = 3'b010,
    TISC_EVENT = 3'b100
  } tisc_mode_t;
endpackage

/* tisc_sync.sv */
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: input may change at any time relative to sys_clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module tisc_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // pin and synchronised level
  input wire logic pin_in,
  input wire logic reset_level,
  output logic level_out
);
  logic stage_one; // metastability catcher
  // ----------------------------------------------------------------
  // two stage capture
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_one <= 1'b1;
      level_out <= 1'b1;
    end else begin
      stage_one <= pin_in;
      level_out <= stage_one;
    end
  end
endmodule
`default_nettype wire

/* tisc_core.sv */
// Purpose: timer/event counter, two-source single level interrupt, status word and call stack control
// Assumes: instruction decoder drives one-cycle strobes; stack ram write and read are done by the core
// Notes: the prescaler divides sys_clk by 480 in place of the oscillator divide
//
// Overview of operation
// - timer mode counts every 480 clocks
// - counter loaded/read by instructions, reset keeps value
// - reset or halt stops; start picks mode
// - counter wraps FF to zero, keeps counting
// - wrap sets overflow, requests vector 7
// - overflow flag tested, cleared by jump, reset
// - taken interrupt blocks others until interrupt exit
// - low level interrupt sampled at strobe, vector 3
// - interrupt pushes pc and upper status
// - external request wins over overflow request
// - preset FF plus falling edge gives vector 7
// - 3-bit pointer selects slots in ram 8-23
// - pointer zero is 8/9; push then increment
// - both returns decrement then reload pc
// - two user flags; only first in status
// - status word bit layout fixed
// - status word moved to/from accumulator
// - half carry from add, used by adjust
// - reset clears pointer, banks, enables, flags
// - reset disables clock out; bus floats unless fetch forced, inputs
// - bank one maps registers to 24-31
`timescale 1ns/1ps
`default_nettype none
module tisc_core (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // pins
  input wire logic event_count_pin,
  input wire logic ext_int_n,
  input wire logic external_fetch_force,
  // machine cycle strobe from sequencer
  input wire logic ale_pulse,
  // instruction strobes
  input wire logic load_count_instr,
  input wire logic start_timer_instr,
  input wire logic start_event_instr,
  input wire logic halt_count_instr,
  input wire logic jump_on_overflow_flag,
  input wire logic ext_int_enable_instr,
  input wire logic ext_int_disable_instr,
  input wire logic tmr_int_enable_instr,
  input wire logic tmr_int_disable_instr,
  input wire logic call_instr,
  input wire logic subroutine_exit_instr,
  input wire logic interrupt_exit_instr,
  input wire logic status_write_instr,
  input wire logic add_instr,
  input wire logic decimal_adjust_instr,
  input wire logic set_flag0_instr,
  input wire logic clr_flag0_instr,
  input wire logic cpl_flag0_instr,
  input wire logic set_flag1_instr,
  input wire logic clr_flag1_instr,
  input wire logic cpl_flag1_instr,
  input wire logic sel_bank0_instr,
  input wire logic sel_bank1_instr,
  input wire logic sel_mem0_instr,
  input wire logic sel_mem1_instr,
  input wire logic enable_clk_out_instr,
  // data from core
  input wire logic [7:0] acc_in,
  input wire logic [11:0] pc_next_in,
  input wire logic alu_carry,
  input wire logic alu_half_carry,
  input wire logic [7:0] stack_lo_in,
  input wire logic [7:0] stack_hi_in,
  // counter and status outputs
  output logic [7:0] count_value,
  output logic [7:0] program_status_word,
  output logic overflow_flag,
  output logic jump_taken,
  output logic user_flag_zero,
  output logic user_flag_one,
  output logic half_carry_used,
  output logic [6:0] reg_bank_base,
  output logic mem_bank,
  // interrupt outputs
  output logic int_take,
  output logic [11:0] int_vector,
  output logic int_in_service,
  // stack access
  output logic stack_push,
  output logic [6:0] stack_addr,
  output logic [7:0] stack_lo_out,
  output logic [7:0] stack_hi_out,
  output logic [11:0] pc_reload,
  output logic pc_reload_en,
  // reset state of pins
  output logic clk_out_enable,
  output logic bus_oe,
  output logic port_drive_low_enable
);
  import tisc_pkg::*;

  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  tisc_mode_t mode; // counter run mode
  logic [PRESCALE_W-1:0] prescale; // divide-by-480 counter
  logic event_sync; // synchronised event pin
  logic event_prev; // last event pin level
  logic int_sync_n; // synchronised interrupt pin
  logic ext_en; // external interrupt enable
  logic tmr_en; // counter interrupt enable
  logic tmr_pending; // overflow request awaiting service
  logic [2:0] stack_index_bits; // stack pointer
  logic register_bank_select; // working bank
  logic half_carry; // nibble carry
  logic carry; // carry
  logic next_wrap; // counter wraps this cycle
  logic count_step; // counter advances this cycle
  logic ext_req; // external request seen at strobe
  logic tmr_req; // counter request
  logic [2:0] pop_index; // pointer after return

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  tisc_sync u_event_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_in(event_count_pin),
    .reset_level(1'b1),
    .level_out(event_sync)
  );
  tisc_sync u_int_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_in(ext_int_n),
    .reset_level(1'b1),
    .level_out(int_sync_n)
  );

  // ----------------------------------------------------------------
  // counter mode
  // ----------------------------------------------------------------
  // reset or halt stops, start picks mode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= TISC_STOPPED;
    end else if (halt_count_instr) begin
      mode <= TISC_STOPPED;
    end else if (start_timer_instr) begin
      mode <= TISC_TIMER;
    end else if (start_event_instr) begin
      mode <= TISC_EVENT;
    end
  end

  // prescaler runs only in timer mode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prescale <= PRESCALE_RESET;
    end else if (mode != TISC_TIMER || prescale == PRESCALE_LAST) begin
      prescale <= PRESCALE_RESET;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // event edge detector on synchronised level
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      event_prev <= 1'b1;
    end else begin
      event_prev <= event_sync;
    end
  end

  // count enable per mode
  always_comb begin
    case (mode)
      TISC_TIMER: count_step = (prescale == PRESCALE_LAST);
      TISC_EVENT: count_step = event_prev & ~event_sync;
      TISC_STOPPED: count_step = 1'b0;
      default: count_step = 1'b0;
    endcase
    next_wrap = count_step && (count_value == COUNT_MAX) && !load_count_instr;
  end

  // counter value: no reset term, only load sets it
  always_ff @(posedge sys_clk) begin
    if (load_count_instr) begin
      count_value <= acc_in;
    end else if (count_step) begin
      count_value <= count_value + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // overflow flag and counter request
  // ----------------------------------------------------------------
  assign jump_taken = jump_on_overflow_flag & overflow_flag;
  // set wins over clear by the jump
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_flag <= 1'b0;
    end else if (next_wrap) begin
      overflow_flag <= 1'b1;
    end else if (jump_on_overflow_flag) begin
      overflow_flag <= 1'b0;
    end
  end

  // pending counter request, cleared when vectored
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_pending <= 1'b0;
    end else if (next_wrap) begin
      tmr_pending <= 1'b1;
    end else if (int_take && !ext_req) begin
      tmr_pending <= 1'b0;
    end else if (tmr_int_disable_instr) begin
      tmr_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt enables and service state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_en <= 1'b0;
      tmr_en <= 1'b0;
    end else begin
      if (ext_int_enable_instr) begin
        ext_en <= 1'b1;
      end else if (ext_int_disable_instr) begin
        ext_en <= 1'b0;
      end
      if (tmr_int_enable_instr) begin
        tmr_en <= 1'b1;
      end else if (tmr_int_disable_instr) begin
        tmr_en <= 1'b0;
      end
    end
  end

  // requests: external only at strobe, external first
  always_comb begin
    ext_req = ale_pulse && !int_sync_n && ext_en;
    tmr_req = tmr_pending && tmr_en;
    int_take = !int_in_service && (ext_req || tmr_req);
    int_vector = ext_req ? VEC_EXT : VEC_TMR;
  end

  // single level: blocked until interrupt exit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_in_service <= 1'b0;
    end else if (int_take) begin
      int_in_service <= 1'b1;
    end else if (interrupt_exit_instr) begin
      int_in_service <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // stack pointer and push/pop data
  // ----------------------------------------------------------------
  assign stack_push = call_instr | int_take;
  assign pop_index = stack_index_bits - 3'd1;
  // slot address: push uses current, pop uses decremented
  always_comb begin
    if (stack_push) begin
      stack_addr = STACK_BASE + {3'b000, stack_index_bits, 1'b0};
    end else begin
      stack_addr = STACK_BASE + {3'b000, pop_index, 1'b0};
    end
    stack_lo_out = pc_next_in[7:0];
    stack_hi_out = {program_status_word[7:4], pc_next_in[11:8]};
    pc_reload = {stack_hi_in[3:0], stack_lo_in};
    pc_reload_en = subroutine_exit_instr | interrupt_exit_instr;
  end

  // pointer: push increments, return decrements, move loads
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stack_index_bits <= 3'b000;
    end else if (stack_push) begin
      stack_index_bits <= stack_index_bits + 3'd1;
    end else if (pc_reload_en) begin
      stack_index_bits <= pop_index;
    end else if (status_write_instr) begin
      stack_index_bits <= acc_in[STW_SP_MSB:STW_SP_LSB];
    end
  end

  // ----------------------------------------------------------------
  // status word upper bits
  // ----------------------------------------------------------------
  // interrupt exit restores upper bits, plain return does not
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      register_bank_select <= 1'b0;
      user_flag_zero <= 1'b0;
      half_carry <= 1'b0;
      carry <= 1'b0;
    end else if (interrupt_exit_instr) begin
      carry <= stack_hi_in[7];
      half_carry <= stack_hi_in[6];
      user_flag_zero <= stack_hi_in[5];
      register_bank_select <= stack_hi_in[4];
    end else if (status_write_instr) begin
      carry <= acc_in[STW_CARRY];
      half_carry <= acc_in[STW_HALF];
      user_flag_zero <= acc_in[STW_FLAG0];
      register_bank_select <= acc_in[STW_BANK];
    end else begin
      if (add_instr) begin
        half_carry <= alu_half_carry;
        carry <= alu_carry;
      end
      if (set_flag0_instr) begin
        user_flag_zero <= 1'b1;
      end else if (clr_flag0_instr) begin
        user_flag_zero <= 1'b0;
      end else if (cpl_flag0_instr) begin
        user_flag_zero <= ~user_flag_zero;
      end
      if (sel_bank1_instr) begin
        register_bank_select <= 1'b1;
      end else if (sel_bank0_instr) begin
        register_bank_select <= 1'b0;
      end
    end
  end

  // second user flag, not in status word
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      user_flag_one <= 1'b0;
    end else if (set_flag1_instr) begin
      user_flag_one <= 1'b1;
    end else if (clr_flag1_instr) begin
      user_flag_one <= 1'b0;
    end else if (cpl_flag1_instr) begin
      user_flag_one <= ~user_flag_one;
    end
  end

  // status word image, bit 3 reads as one
  always_comb begin
    program_status_word = STW_RESET;
    program_status_word[STW_SP_MSB:STW_SP_LSB] = stack_index_bits;
    program_status_word[STW_UNUSED] = 1'b1;
    program_status_word[STW_BANK] = register_bank_select;
    program_status_word[STW_FLAG0] = user_flag_zero;
    program_status_word[STW_HALF] = half_carry;
    program_status_word[STW_CARRY] = carry;
    half_carry_used = decimal_adjust_instr & half_carry;
    reg_bank_base = register_bank_select ? BANK1_BASE : BANK0_BASE;
  end

  // ----------------------------------------------------------------
  // memory bank and pin reset state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_bank <= 1'b0;
      clk_out_enable <= 1'b0;
    end else begin
      if (sel_mem1_instr) begin
        mem_bank <= 1'b1;
      end else if (sel_mem0_instr) begin
        mem_bank <= 1'b0;
      end
      if (enable_clk_out_instr) begin
        clk_out_enable <= 1'b1;
      end
    end
  end

  // bus floats unless external fetch forced; ports weak high
  assign bus_oe = external_fetch_force;
  assign port_drive_low_enable = 1'b0;
endmodule
`default_nettype wire

/* tisc_props.sv */
// Purpose: port-level assertions for the timer, interrupt and status block
// Assumes: single clock domain, reset active low
// Notes: bound to every tisc_core instance
`timescale 1ns/1ps
`default_nettype none
module tisc_props
  import tisc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // watched strobes and data
  input wire logic jump_on_overflow_flag,
  input wire logic load_count_instr,
  input wire logic interrupt_exit_instr,
  input wire logic status_write_instr,
  input wire logic [11:0] pc_next_in,
  // watched outputs
  input wire logic [7:0] count_value,
  input wire logic [7:0] program_status_word,
  input wire logic overflow_flag,
  input wire logic jump_taken,
  input wire logic [6:0] reg_bank_base,
  input wire logic int_take,
  input wire logic int_in_service,
  input wire logic stack_push,
  input wire logic [6:0] stack_addr,
  input wire logic [7:0] stack_hi_out,
  input wire logic pc_reload_en
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  wire logic [2:0] sp = program_status_word[2:0]; // stack index bits
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  jump_flag_a: assert property (jump_taken == (jump_on_overflow_flag && overflow_flag))
    else $error("jump output differs from strobe and flag");
  flag_clear_a: assert property (jump_on_overflow_flag && count_value != COUNT_MAX |=> !overflow_flag)
    else $error("overflow flag survived the jump");
  wrap_set_a: assert property (count_value == COUNT_MAX && !load_count_instr ##1 count_value == 8'h00 |-> overflow_flag)
    else $error("wrap did not set overflow flag");
  take_push_a: assert property (int_take |-> stack_push ##1 int_in_service)
    else $error("taken interrupt did not push and enter service");
  no_reentry_a: assert property (int_in_service |-> !int_take)
    else $error("interrupt taken while in service");
  exit_clear_a: assert property (interrupt_exit_instr && !int_take |=> !int_in_service)
    else $error("interrupt exit left service active");
  push_inc_a: assert property (stack_push && !pc_reload_en && !status_write_instr |=> sp == $past(sp) + 3'd1)
    else $error("push did not step stack index up");
  pop_dec_a: assert property (pc_reload_en && !stack_push && !status_write_instr |=> sp == $past(sp) - 3'd1)
    else $error("return did not step stack index down");
  slot_addr_a: assert property (stack_push |-> stack_addr == STACK_BASE + {3'b000, sp, 1'b0})
    else $error("push slot address wrong");
  hi_byte_a: assert property (stack_push |-> stack_hi_out == {program_status_word[7:4], pc_next_in[11:8]})
    else $error("saved upper byte wrong");
  unused_bit_a: assert property (program_status_word[STW_UNUSED])
    else $error("status bit 3 not one");
  bank_map_a: assert property (reg_bank_base == (program_status_word[STW_BANK] ? BANK1_BASE : BANK0_BASE))
    else $error("register bank base wrong");
endmodule
bind tisc_core tisc_props i_tisc_props (.*);
`default_nettype wire

/* tisc_src_model.sv */
// Purpose: external interrupt and event sources
// Assumes: ale_pulse marks one machine cycle
// Notes: event low and high phases each last three strobes
`timescale 1ns/1ps
`default_nettype none
module tisc_src_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // commands from bench
  input wire logic ale_pulse,
  input wire logic ev_go,
  input wire logic int_req,
  // pins
  output logic event_count_pin,
  output logic ext_int_n
);
  logic [2:0] ale_seen; // strobes seen since the fall
  // low level while a request is held, pulled up otherwise
  assign ext_int_n = !int_req;
  // one falling edge, held low then high three strobes each
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      event_count_pin <= 1'b1;
      ale_seen <= 3'd6;
    end else if (ev_go) begin
      event_count_pin <= 1'b0;
      ale_seen <= 3'd0;
    end else if (ale_pulse && ale_seen != 3'd6) begin
      ale_seen <= ale_seen + 3'd1;
      if (ale_seen == 3'd2) event_count_pin <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench for tisc_core
// Assumes: ale every five clocks, strobes one cycle
// Notes: table of status cases, then counter and interrupt walks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tisc_pkg::*;
  typedef struct packed {logic [4:0] idx; logic [7:0] acc; logic [7:0] stw; logic [1:0] side;} tisc_row_t;
  logic sys_clk, arst_n, event_count_pin, ext_int_n, external_fetch_force, ale_pulse, ev_go, int_req;
  logic load_count_instr, start_timer_instr, start_event_instr, halt_count_instr, jump_on_overflow_flag;
  logic ext_int_enable_instr, ext_int_disable_instr, tmr_int_enable_instr, tmr_int_disable_instr;
  logic call_instr, subroutine_exit_instr, interrupt_exit_instr, status_write_instr, add_instr;
  logic decimal_adjust_instr, set_flag0_instr, clr_flag0_instr, cpl_flag0_instr, set_flag1_instr;
  logic clr_flag1_instr, cpl_flag1_instr, sel_bank0_instr, sel_bank1_instr, sel_mem0_instr;
  logic sel_mem1_instr, enable_clk_out_instr, alu_carry, alu_half_carry, overflow_flag, jump_taken;
  logic user_flag_zero, user_flag_one, half_carry_used, mem_bank, int_take, int_in_service, stack_push;
  logic pc_reload_en, clk_out_enable, bus_oe, port_drive_low_enable;
  logic [7:0] acc_in, stack_lo_in, stack_hi_in, count_value, program_status_word, stack_lo_out, stack_hi_out;
  logic [11:0] pc_next_in, int_vector, pc_reload;
  logic [6:0] reg_bank_base, stack_addr;
  logic [25:0] st; // one bit per instruction strobe
  logic [2:0] ph; // machine cycle phase
  int err_count, tests_run, n;
  // status cases: strobe, accumulator, status word, {mem_bank, user_flag_one}
  localparam tisc_row_t ROWS [17] = '{'{13, 8'h00, 8'h08, 0}, '{13, 8'hf7, 8'hff, 0}, '{13, 8'h00, 8'h08, 0},
    '{10, 0, 8'h28, 0}, '{8, 0, 8'h08, 0}, '{8, 0, 8'h28, 0}, '{9, 0, 8'h08, 0}, '{7, 0, 8'h08, 1},
    '{5, 0, 8'h08, 0}, '{3, 0, 8'h18, 0}, '{4, 0, 8'h08, 0}, '{1, 0, 8'h08, 2}, '{2, 0, 8'h08, 0},
    '{12, 8'hc0, 8'hc8, 0}, '{16, 0, 8'hc9, 0}, '{15, 0, 8'hc8, 0}, '{12, 0, 8'h08, 0}};
  assign {load_count_instr, start_timer_instr, start_event_instr, halt_count_instr, jump_on_overflow_flag,
    ext_int_enable_instr, ext_int_disable_instr, tmr_int_enable_instr, tmr_int_disable_instr, call_instr,
    subroutine_exit_instr, interrupt_exit_instr, status_write_instr, add_instr, decimal_adjust_instr,
    set_flag0_instr, clr_flag0_instr, cpl_flag0_instr, set_flag1_instr, clr_flag1_instr, cpl_flag1_instr,
    sel_bank0_instr, sel_bank1_instr, sel_mem0_instr, sel_mem1_instr, enable_clk_out_instr} = st;
  assign {alu_carry, alu_half_carry} = acc_in[7:6];
  assign pc_next_in = {acc_in[3:0], acc_in};
  assign ale_pulse = ph == 3'd0;
  tisc_core i_tisc_core (.*);
  tisc_src_model i_tisc_src_model (.*);
  // ----------------------------------------------------------------
  // clock, machine cycle and helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) #1 ph = (ph == 3'd4) ? 3'd0 : ph + 3'd1;
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hold(input int idx);
    @(posedge sys_clk);
    #1 st = 26'h1 << idx;
    #1;
  endtask
  task automatic drop();
    @(posedge sys_clk);
    #1 st = '0;
  endtask
  task automatic pulse(input int idx, input logic [7:0] a);
    acc_in = a;
    hold(idx);
    drop();
  endtask
  task automatic wait_chg(input logic [7:0] v);
    n = 0;
    while (count_value === v && n < 600) begin
      @(posedge sys_clk);
      #1 n++;
    end
  endtask
  task automatic wait_take(input int lim);
    for (n = 0; int_take !== 1'b1 && n < lim; n++) @(posedge sys_clk) #2;
  endtask
  task automatic ev_fall();
    @(posedge sys_clk) #1 ev_go = 1'b1;
    @(posedge sys_clk) #1 ev_go = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, external_fetch_force, ev_go, int_req, st, ph, acc_in, stack_lo_in, stack_hi_in} = '0;
    err_count = 0;
    tests_run = 0;
    repeat (10) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    chk("rst status", program_status_word, 8'h08);
    chk("rst flags", {overflow_flag, user_flag_zero, user_flag_one, mem_bank, int_in_service}, 0);
    chk("rst pins", {clk_out_enable, bus_oe, port_drive_low_enable}, 0);
    external_fetch_force = 1'b1;
    #1 chk("bus forced", bus_oe, 1);
    external_fetch_force = 1'b0;
    foreach (ROWS[i]) begin
      pulse(ROWS[i].idx, ROWS[i].acc);
      chk("row status", program_status_word, ROWS[i].stw);
      chk("row side", {mem_bank, user_flag_one}, ROWS[i].side);
      chk("row bank", reg_bank_base, ROWS[i].stw[STW_BANK] ? BANK1_BASE : BANK0_BASE);
    end
    pulse(13, 8'h40);
    hold(11);
    chk("adjust", half_carry_used, 1);
    drop();
    // timer mode, counter interrupt disabled
    pulse(25, 8'hfe);
    chk("load", count_value, 8'hfe);
    pulse(24, 0);
    wait_chg(8'hfe);
    wait_chg(8'hff);
    chk("period", n[11:0], 12'(TIMER_DIV));
    chk("wrap", {count_value, overflow_flag, int_in_service}, 12'h002);
    pulse(22, 0);
    repeat (520) @(posedge sys_clk);
    chk("halted", count_value, 8'h00);
    hold(21);
    chk("jump", jump_taken, 1);
    drop();
    chk("flag clr", overflow_flag, 0);
    // event mode preset to terminal count FF; disable first drops the wrap left pending
    pulse(17, 0);
    pulse(18, 0);
    pulse(20, 0);
    pulse(25, 8'hff);
    pulse(23, 8'h5c);
    chk("no early", int_in_service, 0);
    ev_fall();
    wait_take(300);
    chk("tmr take", int_take, 1);
    chk("tmr vec", int_vector, VEC_TMR);
    chk("push lo", stack_lo_out, 8'h5c);
    chk("push hi", stack_hi_out, 8'h4c);
    @(posedge sys_clk) #1;
    chk("svc", {int_in_service, program_status_word[2:0]}, 4'h9);
    // both sources pending while in service
    int_req = 1'b1;
    pulse(25, 8'hff);
    repeat (20) @(posedge sys_clk);
    ev_fall();
    wait_take(80);
    chk("blocked", int_take, 0);
    {stack_lo_in, stack_hi_in} = 16'h34a2;
    // time the exit so that the first free cycle is a strobe cycle
    while (!ale_pulse) @(posedge sys_clk) #2;
    repeat (3) @(posedge sys_clk) #2;
    hold(14);
    chk("reload", {pc_reload_en, pc_reload}, 13'h1234);
    drop();
    chk("pop status", program_status_word, 8'ha8);
    #1 wait_take(300);
    chk("ext first", int_vector, VEC_EXT);
    int_req = 1'b0;
    repeat (4) @(posedge sys_clk);
    pulse(14, 0);
    wait_take(300);
    chk("tmr take2", int_take, 1);
    chk("tmr next", int_vector, VEC_TMR);
    repeat (2) @(posedge sys_clk);
    pulse(14, 0);
    pulse(17, 0);
    pulse(19, 0);
    int_req = 1'b1;
    pulse(25, 8'hff);
    ev_fall();
    wait_take(80);
    chk("disabled", int_take, 0);
    chk("wrap off", count_value, 8'h00);
    int_req = 1'b0;
    // reset in mid-run keeps the count and stops it
    pulse(0, 0);
    chk("clk out", clk_out_enable, 1);
    pulse(24, 0);
    pulse(25, 8'h5a);
    arst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    chk("rst pins2", {clk_out_enable, program_status_word}, 12'h008);
    repeat (520) @(posedge sys_clk);
    chk("rst count", count_value, 8'h5a);
    report_and_stop();
  end
endmodule
`default_nettype wire
